// >>> rtl/cbccb_pkg.sv
package cbccb_pkg;

  // opcodes handled by this execution slice
  localparam logic [7:0] OP_CMPJMP_A_DIR = 8'hB5;
  localparam logic [7:0] OP_CMPJMP_A_IMM = 8'hB4;
  localparam logic [6:0] OP_CMPJMP_IND_HI = 7'h5B; // 1011011i
  localparam logic [4:0] OP_CMPJMP_REG_HI = 5'h17; // 10111rrr
  localparam logic [7:0] OP_CLEAR_ACC = 8'hE4;
  localparam logic [7:0] OP_CLEAR_CY = 8'hC3;
  localparam logic [7:0] OP_CLEAR_BIT = 8'hC2;
  localparam logic [7:0] OP_COMPL_ACC = 8'hF4;
  localparam logic [7:0] OP_COMPL_CY = 8'hB3;
  localparam logic [7:0] OP_COMPL_BIT = 8'hB2;
  localparam logic [7:0] OP_DEC_ADJ = 8'hD4;

  // instruction lengths in bytes, added to the program counter
  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam logic [15:0] LEN_TWO = 16'h0002;
  localparam logic [15:0] LEN_THREE = 16'h0003;

  // machine cycles per instruction
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // decimal adjust constants
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [8:0] ADJ_NONE = 9'h000;
  localparam logic [8:0] ADJ_LOW = 9'h006;
  localparam logic [8:0] ADJ_HIGH = 9'h060;

  localparam logic [7:0] ACC_ZERO = 8'h00;

  // one decoded instruction handed over by fetch/decode
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1; // direct/bit address or immediate data
    logic [7:0] byte2; // relative displacement
    logic [15:0] pc; // address of the opcode byte
    logic [7:0] acc;
    logic carry;
    logic auxCarry;
    logic [7:0] operandVal; // direct byte, working register or indirect byte
    logic bitReadVal; // addressed bit as normally read
    logic bitLatchVal; // output data latch bit of a port
    logic bitIsPort; // addressed bit belongs to an output port
  } cbccb_req_t;

  // write-back and sequencing result
  typedef struct packed {
    logic done;
    logic unknownOp;
    logic [15:0] nextPc;
    logic accWe;
    logic [7:0] accVal;
    logic cyWe;
    logic cyVal;
    logic bitWe;
    logic [7:0] bitAddr;
    logic bitVal;
    logic [1:0] cycles;
  } cbccb_res_t;

endpackage

// >>> rtl/cbccb_exec.sv
// Contract
// - compare-jump branches to next plus displacement when unequal
// - carry set when destination below source, operands kept
// - four compare forms: direct, immediate, indirect, register
// - compare forms three bytes, two cycles, pc plus three
// - compare decoded by nibble 1011 and low forms
// - clear accumulator zeroes all bits, flags kept
// - clear carry or addressed bit, nothing else
// - complement accumulator inverts all bits, flags kept
// - complement carry or addressed bit, nothing else
// - port bit complement reads output latch, not pin
// - decimal adjust adds six on low digit overflow
// - low correction carry sets carry, never clears
// - high correction adds sixty, sets carry, never clears
// - decimal adjust one byte, one cycle, overflow untouched
module cbccb_exec (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // instruction request from fetch/decode
  input wire logic reqValid,
  input wire cbccb_pkg::cbccb_req_t req,
  output logic reqReady,
  // write-back result
  output cbccb_pkg::cbccb_res_t res
);

  // a compare-and-jump spends its second machine cycle in CBCCB_SECOND
  typedef enum logic {CBCCB_IDLE, CBCCB_SECOND} cbccb_state_t;

  // one flag per instruction class; none is raised for an opcode outside this slice
  typedef struct packed {
    logic cmpJump;
    logic clearAcc;
    logic clearCarry;
    logic clearBit;
    logic invertAcc;
    logic invertCarry;
    logic invertBit;
    logic decAdjust;
  } cbccb_dec_t;

  // sequencing state
  cbccb_state_t state_r;
  cbccb_state_t state_nxt;
  // answer presented to the core; done is a one-cycle pulse, the rest holds
  cbccb_pkg::cbccb_res_t res_r;
  cbccb_pkg::cbccb_res_t res_nxt;
  // answer of a compare, parked over its second machine cycle
  cbccb_pkg::cbccb_res_t pend_r;
  cbccb_pkg::cbccb_res_t pend_nxt;
  // request acceptance
  logic ready_r;
  logic ready_nxt;

  // decode of the presented opcode
  cbccb_dec_t dec;
  // operand selection and compare
  logic [7:0] cmpDest;
  logic [7:0] cmpSrc;
  logic cmpUnequal;
  logic cmpBelow;
  // program counter candidates
  logic [15:0] relExt;
  logic [15:0] pcOneByte;
  logic [15:0] pcTwoByte;
  logic [15:0] pcSeq;
  logic [15:0] pcBranch;
  // bit operand
  logic bitSrc;
  // decimal adjust
  logic lowFix;
  logic highFix;
  logic [8:0] adjLow;
  logic [8:0] adjHigh;
  logic adjCarryMid;
  logic adjCarryOut;
  // execution result and handshake
  cbccb_pkg::cbccb_res_t exe;
  logic takeReq;
  logic takeOne;
  logic takeTwo;

  // opcode decoder; the compare forms share the upper nibble and differ in the low one
  always_comb begin
    dec = '0;
    if (req.opcode == cbccb_pkg::OP_CMPJMP_A_DIR) begin
      dec.cmpJump = 1'b1;
    end
    if (req.opcode == cbccb_pkg::OP_CMPJMP_A_IMM) begin
      dec.cmpJump = 1'b1;
    end
    if (req.opcode[7:1] == cbccb_pkg::OP_CMPJMP_IND_HI) begin
      dec.cmpJump = 1'b1;
    end
    if (req.opcode[7:3] == cbccb_pkg::OP_CMPJMP_REG_HI) begin
      dec.cmpJump = 1'b1;
    end
    case (req.opcode)
      cbccb_pkg::OP_CLEAR_ACC: begin
        dec.clearAcc = 1'b1;
      end
      cbccb_pkg::OP_CLEAR_CY: begin
        dec.clearCarry = 1'b1;
      end
      cbccb_pkg::OP_CLEAR_BIT: begin
        dec.clearBit = 1'b1;
      end
      cbccb_pkg::OP_COMPL_ACC: begin
        dec.invertAcc = 1'b1;
      end
      cbccb_pkg::OP_COMPL_CY: begin
        dec.invertCarry = 1'b1;
      end
      cbccb_pkg::OP_COMPL_BIT: begin
        dec.invertBit = 1'b1;
      end
      cbccb_pkg::OP_DEC_ADJ: begin
        dec.decAdjust = 1'b1;
      end
      default: begin
        // not ours: every class flag stays low
      end
    endcase
  end

  // operand selection for the compare forms; the accumulator is the destination by default
  always_comb begin
    cmpDest = req.acc;
    cmpSrc = req.byte1;
    if (req.opcode == cbccb_pkg::OP_CMPJMP_A_DIR) begin
      cmpSrc = req.operandVal;
    end else if (req.opcode[7:1] == cbccb_pkg::OP_CMPJMP_IND_HI) begin
      cmpDest = req.operandVal;
    end else if (req.opcode[7:3] == cbccb_pkg::OP_CMPJMP_REG_HI) begin
      cmpDest = req.operandVal;
    end
  end

  // compare outcome; the operands themselves are never written back
  assign cmpUnequal = cmpDest != cmpSrc;
  assign cmpBelow = cmpDest < cmpSrc;

  // sign-extend the displacement once; every adder wraps at 64 KiB like the core's counter
  assign relExt = {{8{req.byte2[7]}}, req.byte2};
  assign pcOneByte = req.pc + cbccb_pkg::LEN_ONE;
  assign pcTwoByte = req.pc + cbccb_pkg::LEN_TWO;
  assign pcSeq = req.pc + cbccb_pkg::LEN_THREE;
  assign pcBranch = pcSeq + relExt;

  // a port bit is complemented from its latch so a loaded pin cannot flip it back
  assign bitSrc = req.bitIsPort ? req.bitLatchVal : req.bitReadVal;

  // decimal adjust: two corrections chained in one cycle, depth traded for a one-cycle answer
  always_comb begin
    lowFix = (req.acc[3:0] > cbccb_pkg::BCD_NINE) || req.auxCarry;
    adjLow = {1'b0, req.acc} + (lowFix ? cbccb_pkg::ADJ_LOW : cbccb_pkg::ADJ_NONE);
    adjCarryMid = req.carry | adjLow[8];
    highFix = adjCarryMid || (adjLow[7:4] > cbccb_pkg::BCD_NINE);
    adjHigh = {1'b0, adjLow[7:0]} + (highFix ? cbccb_pkg::ADJ_HIGH : cbccb_pkg::ADJ_NONE);
    adjCarryOut = adjCarryMid | adjHigh[8];
  end

  // result of the instruction; flags not named here are left alone
  always_comb begin
    exe = '0;
    exe.done = 1'b1;
    exe.bitAddr = req.byte1;
    exe.cycles = cbccb_pkg::CYC_ONE;
    exe.nextPc = pcOneByte;
    if (dec.cmpJump) begin
      exe.cycles = cbccb_pkg::CYC_TWO;
      exe.nextPc = cmpUnequal ? pcBranch : pcSeq;
      exe.cyWe = 1'b1;
      exe.cyVal = cmpBelow;
    end else if (dec.clearAcc) begin
      exe.accWe = 1'b1;
      exe.accVal = cbccb_pkg::ACC_ZERO;
    end else if (dec.clearCarry) begin
      exe.cyWe = 1'b1;
      exe.cyVal = 1'b0;
    end else if (dec.clearBit) begin
      exe.nextPc = pcTwoByte;
      exe.bitWe = 1'b1;
      exe.bitVal = 1'b0;
    end else if (dec.invertAcc) begin
      exe.accWe = 1'b1;
      exe.accVal = ~req.acc;
    end else if (dec.invertCarry) begin
      exe.cyWe = 1'b1;
      exe.cyVal = ~req.carry;
    end else if (dec.invertBit) begin
      exe.nextPc = pcTwoByte;
      exe.bitWe = 1'b1;
      exe.bitVal = ~bitSrc;
    end else if (dec.decAdjust) begin
      // overflow has no write enable here, so it stays as it was
      exe.accWe = 1'b1;
      exe.accVal = adjHigh[7:0];
      exe.cyWe = 1'b1;
      exe.cyVal = adjCarryOut;
    end else begin
      // not ours: answer at once with no write so the core is never hung
      exe.unknownOp = 1'b1;
    end
  end

  // a request is taken only in idle; in the second machine cycle ready holds it off
  assign takeReq = reqValid && ready_r && (state_r == CBCCB_IDLE);
  assign takeOne = takeReq && (exe.cycles != cbccb_pkg::CYC_TWO);
  assign takeTwo = takeReq && (exe.cycles == cbccb_pkg::CYC_TWO);

  // state: a taken compare moves to the second cycle, which always returns to idle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CBCCB_IDLE: begin
        if (takeTwo) begin
          state_nxt = CBCCB_SECOND;
        end
      end
      CBCCB_SECOND: begin
        state_nxt = CBCCB_IDLE;
      end
      default: begin
        state_nxt = CBCCB_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= CBCCB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ready: low for exactly the second cycle of a compare, so no request can slip in
  always_comb begin
    ready_nxt = ready_r;
    case (state_r)
      CBCCB_IDLE: begin
        if (takeTwo) begin
          ready_nxt = 1'b0;
        end
      end
      CBCCB_SECOND: begin
        ready_nxt = 1'b1;
      end
      default: begin
        ready_nxt = 1'b1;
      end
    endcase
  end

  // ready register; high out of reset so the first request can be taken at once
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ready_r <= 1'b1;
    end else begin
      ready_r <= ready_nxt;
    end
  end

  // parked compare answer; loaded only when a compare is taken
  always_comb begin
    pend_nxt = pend_r;
    if (takeTwo) begin
      pend_nxt = exe;
    end
  end

  // parked answer register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // answer: one-cycle forms answer at once, a compare after its parked cycle
  always_comb begin
    res_nxt = res_r;
    res_nxt.done = 1'b0;
    case (state_r)
      CBCCB_IDLE: begin
        if (takeOne) begin
          res_nxt = exe;
        end
      end
      CBCCB_SECOND: begin
        res_nxt = pend_r;
      end
      default: begin
        res_nxt.done = 1'b0;
      end
    endcase
  end

  // answer register; every field but done holds between done pulses
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      res_r <= '0;
    end else begin
      res_r <= res_nxt;
    end
  end

  // every output comes straight from a register
  assign reqReady = ready_r;
  assign res = res_r;

endmodule

// >>> bench/cbccb_monitor.sv
module cbccb_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // request and result
  input wire logic reqValid,
  input wire cbccb_pkg::cbccb_req_t req,
  input wire logic reqReady,
  input wire cbccb_pkg::cbccb_res_t res
);
  timeunit 1ns;
  timeprecision 1ps;
  // taken request and its opcode
  wire tk = reqValid && reqReady;
  wire [7:0] op = req.opcode;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // results land one edge after the take, compares one edge later
  a_cmp_latency: assert property (tk && op[7:4] == 4'hB && op[3:2] != 2'h0 |=> !reqReady ##1 res.done)
    else $error("compare latency wrong");
  a_cmp_equal_pc: assert property (tk && op == 8'hB4 && req.acc == req.byte1 |-> ##2 res.nextPc == $past(req.pc, 2) + 16'h0003)
    else $error("equal compare pc wrong");
  a_cmp_carry: assert property (tk && op == 8'hB5 |-> ##2 res.cyVal == ($past(req.acc, 2) < $past(req.operandVal, 2)))
    else $error("compare carry wrong");
  a_clear_acc: assert property (tk && op == 8'hE4 |=> res.accWe && res.accVal == 8'h00 && !res.cyWe)
    else $error("clear acc wrong");
  a_invert_acc: assert property (tk && op == 8'hF4 |=> res.accVal == ~$past(req.acc) && !res.cyWe)
    else $error("complement acc wrong");
  a_clear_carry: assert property (tk && op == 8'hC3 |=> res.cyWe && !res.cyVal && !res.bitWe)
    else $error("clear carry wrong");
  a_invert_port: assert property (tk && op == 8'hB2 && req.bitIsPort |=> res.bitVal == !$past(req.bitLatchVal))
    else $error("port bit source wrong");
  a_adjust_carry: assert property (tk && op == 8'hD4 && req.carry |=> res.cyWe && res.cyVal)
    else $error("adjust cleared carry");
endmodule
bind cbccb_exec cbccb_monitor u_mon (.clk_sys(clk_sys), .sys_rst(sys_rst), .reqValid(reqValid), .req(req),
  .reqReady(reqReady), .res(res));

// >>> bench/cbccb_tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus, notes and counters
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic reqValid = 1'b0;
  cbccb_pkg::cbccb_req_t req = '0;
  logic reqReady;
  cbccb_pkg::cbccb_res_t res;
  cbccb_pkg::cbccb_res_t expQ[$];
  cbccb_pkg::cbccb_res_t e;
  logic [7:0] ops[14] = '{8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hBF, 8'hE4,
    8'hC3, 8'hC2, 8'hF4, 8'hB3, 8'hB2, 8'hD4, 8'hA5};
  integer seed = 32'h01eb49bb;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  always #10 clk_sys = ~clk_sys;
  cbccb_exec DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .res(res));
  // reference result of one instruction
  function automatic cbccb_pkg::cbccb_res_t model(input cbccb_pkg::cbccb_req_t r);
    cbccb_pkg::cbccb_res_t m;
    logic [7:0] d;
    logic [7:0] s;
    logic [8:0] a;
    logic c;
    m = '0;
    m.done = 1'b1;
    m.cycles = 2'h1;
    d = (r.opcode[3:1] == 3'h2) ? r.acc : r.operandVal;
    s = (r.opcode == 8'hB5) ? r.operandVal : r.byte1;
    a = {1'b0, r.acc} + ((r.acc[3:0] > 4'h9 || r.auxCarry) ? 9'h006 : 9'h000);
    c = r.carry | a[8];
    a = {1'b0, a[7:0]} + ((a[7:4] > 4'h9 || c) ? 9'h060 : 9'h000);
    m.accWe = r.opcode inside {8'hE4, 8'hF4, 8'hD4};
    m.accVal = (r.opcode == 8'hF4) ? ~r.acc : (r.opcode == 8'hD4) ? a[7:0] : 8'h00;
    m.cyWe = r.opcode inside {8'hC3, 8'hB3, 8'hD4};
    m.cyVal = (r.opcode == 8'hB3) ? ~r.carry : (r.opcode == 8'hD4) && (c | a[8]);
    m.bitWe = r.opcode inside {8'hC2, 8'hB2};
    m.bitAddr = r.byte1;
    m.bitVal = (r.opcode == 8'hB2) && !(r.bitIsPort ? r.bitLatchVal : r.bitReadVal);
    m.nextPc = r.pc + (m.bitWe ? 16'h0002 : 16'h0001);
    if (r.opcode[7:4] == 4'hB && r.opcode[3:2] != 2'h0) begin
      m.cyWe = 1'b1;
      m.cyVal = d < s;
      m.cycles = 2'h2;
      m.nextPc = r.pc + 16'h0003 + ((d != s) ? {{8{r.byte2[7]}}, r.byte2} : 16'h0000);
    end
    m.unknownOp = !(m.accWe | m.cyWe | m.bitWe);
    return m;
  endfunction
  // values not written back are zeroed so they never decide a match
  function automatic cbccb_pkg::cbccb_res_t norm(input cbccb_pkg::cbccb_res_t r);
    norm = r;
    if (!r.accWe) norm.accVal = 8'h00;
    if (!r.cyWe) norm.cyVal = 1'b0;
    if (!r.bitWe) norm.bitAddr = 8'h00;
    if (!r.bitWe) norm.bitVal = 1'b0;
  endfunction
  // random request; half of them make the compared operands equal
  function automatic cbccb_pkg::cbccb_req_t rnd();
    logic [63:0] w;
    cbccb_pkg::cbccb_req_t r;
    w = {$random(seed), $random(seed)};
    r = w[60:0];
    r.opcode = ops[$unsigned($random(seed)) % 14];
    if (r.byte2[0]) begin
      r.acc = r.byte1;
      r.operandVal = r.byte1;
    end
    return rnd_ret(r);
  endfunction
  function automatic cbccb_pkg::cbccb_req_t rnd_ret(input cbccb_pkg::cbccb_req_t r);
    return r;
  endfunction
  task end_of_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // driver: note each taken request, hold an untaken one
  always @(posedge clk_sys) begin
    if (!sys_rst && reqValid && reqReady) expQ.push_back(model(req));
    if (!sys_rst && (!reqValid || reqReady)) begin
      reqValid <= (cyc < 3000) && ($random(seed) % 4 != 0);
      req <= rnd();
    end
  end
  // watcher: each done pulse takes the oldest note
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      miscompares++;
      $display("CHECK FAILED timeout expected %0d seen %0d", 5000, cyc);
      end_of_test();
    end else if (!sys_rst && res.done === 1'b1) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : '0;
      num_checks++;
      if (norm(res) !== norm(e)) begin
        miscompares++;
        $display("CHECK FAILED res expected %h seen %h", norm(e), norm(res));
      end
    end
  end
  // reset, run, then look for results that never came
  initial begin
    repeat (3) @(posedge clk_sys);
    num_checks++;
    if (reqReady !== 1'b1 || res !== '0) begin
      miscompares++;
      $display("CHECK FAILED reset expected 1 0 seen %b %h", reqReady, res);
    end
    sys_rst <= 1'b0;
    repeat (3010) @(posedge clk_sys);
    if (expQ.size() != 0) begin
      miscompares++;
      $display("CHECK FAILED pending expected 0 seen %0d", expQ.size());
    end
    end_of_test();
  end
endmodule
